/* File: include/swdp_defines.svh */
// timing counts, command codes and address constants of the single-wire debug port
`ifndef SWDP_DEFINES_SVH
`define SWDP_DEFINES_SVH

// ----------------------------------------
// bit timing and other counts in debug-clock cycles, word length in bits
// ----------------------------------------
`define SWDP_BIT_CYC 5'd16
`define SWDP_SAMPLE_CYC 5'd10
`define SWDP_ONE_PULSE_CYC 5'd7
`define SWDP_ZERO_LOW_CYC 5'd13
`define SWDP_TIMEOUT_CYC 11'd512
`define SWDP_STEAL_CYC 8'd128
`define SWDP_DENY_CYC 4'd8
`define SWDP_WORD_BITS 5'd16

// ----------------------------------------
// command codes and command fields
// ----------------------------------------
`define SWDP_CMD_BACKGROUND 8'h90
`define SWDP_CMD_RD_BYTE_DBG 8'hE4
`define SWDP_CMD_RD_WORD_DBG 8'hEC
`define SWDP_CMD_RD_BYTE 8'hE0
`define SWDP_CMD_RD_WORD 8'hE8
`define SWDP_CMD_WR_BYTE_DBG 8'hC4
`define SWDP_CMD_WR_WORD_DBG 8'hCC
`define SWDP_CMD_WR_BYTE 8'hC0
`define SWDP_CMD_WR_WORD 8'hC8
`define SWDP_CMD_READ_BIT 5
`define SWDP_CMD_WORD_BIT 3
`define SWDP_CMD_MAP_BIT 2

// ----------------------------------------
// debug register window and status byte
// ----------------------------------------
`define SWDP_DBG_REG_LO 16'hFF00
`define SWDP_DBG_REG_HI 16'hFF06
`define SWDP_STATUS_ADDR 16'hFF01
`define SWDP_STAT_EN_BIT 7
`define SWDP_STAT_ACT_BIT 6

// ----------------------------------------
// receive buffer shape
// ----------------------------------------
`define SWDP_FIFO_W 8
`define SWDP_FIFO_D 8

`endif

/* File: include/swdp_pkg.sv */
// types of the single-wire debug port
package swdp_pkg;

  // ----------------------------------------
  // command sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_WDATA = 3'b010,
    ST_WAIT = 3'b011,
    ST_MEM = 3'b100,
    ST_SEND = 3'b101
  } swdp_cmd_st_e;

  // ----------------------------------------
  // whole state of the port
  // ----------------------------------------
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic busy;
    logic [4:0] cnt;
    logic [10:0] idle;
    logic tx_on;
    logic txbit;
    logic [15:0] tx_sh;
    logic [4:0] tx_left;
    logic [7:0] rx_sh;
    logic [2:0] rx_n;
    logic rx_full;
    swdp_cmd_st_e fsm;
    logic [7:0] cmd;
    logic bsel;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [7:0] steal;
    logic freeze;
    logic hold;
    logic mem_req;
    logic mem_we;
    logic mem_byte;
    logic mem_dbg;
    logic fw_en;
    logic active;
    logic bg_req;
    logic strap_done;
    logic [3:0] deny;
    logic wire_out;
    logic wire_oe;
  } swdp_state_s;

endpackage

/* File: rtl/swdp_fifo.sv */
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module swdp_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } swdp_fifo_s;

  swdp_fifo_s state;
  swdp_fifo_s next_state;

  // extra pointer bit tells full from empty
  assign o_ready = (state.wp - state.rp) != (AW+1)'(D);
  assign o_valid = state.wp != state.rp;
  assign o_data = state.mem[state.rp[AW-1:0]];

  always_comb begin
    next_state = state;
    if (i_valid && o_ready) begin
      next_state.mem[state.wp[AW-1:0]] = i_data;
      next_state.wp = state.wp + (AW+1)'(1);
    end
    if (i_ready && o_valid) begin
      next_state.rp = state.rp + (AW+1)'(1);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule

/* File: rtl/swdp_port.sv */
// single-wire background debug port: bit engine, hardware commands, mode control
//
// How it works
// - host sets firmware enable via byte write
// - active mode maps debug registers and rom
// - activation sources; refused without firmware enable
// - serial entry waits for instruction boundary
// - special single-chip mode starts already active
// - debug registers mapped by the command's map bit, whether active or not
// - peripherals suspend while debug mode active
// - msb first, sixteen cycles per bit
// - 512 idle cycles clears command state
// - sample wire ten cycles after bit start
// - one bit: speed-up pulse at cycle seven
// - zero bit: low thirteen cycles, then high
// - free bus cycle, else steal after 128
// - firmware commands need active background mode
// - command 90 enters background when enabled
// - read commands: address in, sixteen bits out
// - write commands: address then sixteen data bits
// - byte data: odd low, even high
// - command byte, then address and data
// - debug resources enabled only during access
`timescale 1ns/1ps
`include "swdp_defines.svh"
module swdp_port (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_wire_in,
  output logic o_wire_out,
  output logic o_wire_oe,
  input wire logic i_free_cycle,
  input wire logic i_mem_ack,
  input wire logic [15:0] i_mem_rdata,
  output logic o_mem_req,
  output logic o_mem_we,
  output logic o_mem_byte,
  output logic o_mem_dbg_map,
  output logic [15:0] o_mem_addr,
  output logic [15:0] o_mem_wdata,
  output logic o_cpu_freeze,
  input wire logic i_insn_boundary,
  input wire logic i_tag_hit,
  input wire logic i_enter_debug_instruction_insn,
  input wire logic i_fw_go,
  input wire logic i_special_single_chip,
  output logic o_background_debug_mode,
  output logic o_debug_firmware_enable,
  output logic o_periph_suspend
);
  swdp_pkg::swdp_state_s state;
  swdp_pkg::swdp_state_s next_state;
  logic fall;
  logic rx_samp;
  logic trig;
  logic pop;
  logic fifo_rdy;
  logic fifo_vld;
  logic [7:0] fifo_data;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  // ----------------------------------------
  // receive buffer
  // ----------------------------------------
  // a full buffer leaves the byte in the shifter, where the next incoming bits overwrite it
  swdp_fifo #(
    .W(`SWDP_FIFO_W),
    .D(`SWDP_FIFO_D)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_valid(state.rx_full),
    .o_ready(fifo_rdy),
    .i_data(state.rx_sh),
    .o_valid(fifo_vld),
    .i_ready(pop),
    .o_data(fifo_data)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // first sync stage is only read by the second one
  assign fall = state.s3 & ~state.s2;
  assign rx_samp = state.busy & ~state.tx_on & (state.cnt == `SWDP_SAMPLE_CYC);
  assign trig = (state.bg_req & i_insn_boundary) | i_tag_hit | i_enter_debug_instruction_insn;
  assign pop = fifo_vld && (state.fsm == swdp_pkg::ST_IDLE || state.fsm == swdp_pkg::ST_ADDR
               || state.fsm == swdp_pkg::ST_WDATA);

  function automatic logic [15:0] lane(input logic byte_acc, input logic odd,
                                       input logic [15:0] w);
    if (!byte_acc) begin
      lane = w;
    end else if (odd) begin
      lane = {8'h00, w[7:0]};
    end else begin
      lane = {w[15:8], 8'h00};
    end
  endfunction

  always_comb begin
    logic [7:0] stat;
    logic [15:0] regw;
    logic mapped;
    stat = 8'h00;
    regw = 16'h0000;
    mapped = 1'b0;
    next_state = state;
    next_state.s1 = i_wire_in;
    next_state.s2 = state.s1;
    next_state.s3 = state.s2;

    // ----------------------------------------
    // bit engine
    // ----------------------------------------
    // host edge opens the bit
    if (fall) begin
      next_state.busy = 1'b1;
      next_state.cnt = 5'd0;
      next_state.idle = 11'd0;
      next_state.tx_on = state.tx_left != 5'd0;
      next_state.txbit = state.tx_sh[15];
      if (state.tx_left != 5'd0) begin
        next_state.tx_sh = {state.tx_sh[14:0], 1'b0};
        next_state.tx_left = state.tx_left - 5'd1;
      end
    end else begin
      if (state.idle != `SWDP_TIMEOUT_CYC) begin
        next_state.idle = state.idle + 11'd1;
      end
      if (state.busy) begin
        next_state.cnt = state.cnt + 5'd1;
        if (state.cnt == `SWDP_BIT_CYC - 5'd1) begin
          next_state.busy = 1'b0;
          next_state.tx_on = 1'b0;
        end
      end
    end
    if (fifo_rdy) begin
      next_state.rx_full = 1'b0;
    end
    // sample ten cycles after the perceived start
    if (rx_samp) begin
      next_state.rx_sh = {state.rx_sh[6:0], state.s2};
      next_state.rx_n = state.rx_n + 3'd1;
      if (state.rx_n == 3'd7) begin
        next_state.rx_full = 1'b1;
      end
    end

    // ----------------------------------------
    // mode control
    // ----------------------------------------
    // strap caught on the first cycle after reset
    if (!state.strap_done) begin
      next_state.strap_done = 1'b1;
      if (i_special_single_chip) begin
        next_state.fw_en = 1'b1;
        next_state.active = 1'b1;
      end
    end
    if (state.deny != 4'd0) begin
      next_state.deny = state.deny - 4'd1;
    end
    if (trig && !state.active) begin
      next_state.bg_req = 1'b0;
      if (state.fw_en) begin
        next_state.active = 1'b1;
      end else begin
        next_state.deny = `SWDP_DENY_CYC;
      end
    end
    if (state.active && i_fw_go) begin
      next_state.active = 1'b0;
    end

    // ----------------------------------------
    // command sequencer
    // ----------------------------------------
    unique case (state.fsm)
      swdp_pkg::ST_IDLE: begin
        next_state.bsel = 1'b0;
        next_state.steal = 8'd0;
        // every command opens with its code
        if (pop) begin
          next_state.cmd = fifo_data;
          case (fifo_data)
            `SWDP_CMD_BACKGROUND: next_state.bg_req = 1'b1;
            `SWDP_CMD_RD_BYTE_DBG, `SWDP_CMD_RD_WORD_DBG, `SWDP_CMD_RD_BYTE,
            `SWDP_CMD_RD_WORD, `SWDP_CMD_WR_BYTE_DBG, `SWDP_CMD_WR_WORD_DBG,
            `SWDP_CMD_WR_BYTE, `SWDP_CMD_WR_WORD: begin
              next_state.fsm = swdp_pkg::ST_ADDR;
            end
            // firmware codes belong to the debug rom, not to this logic
            default: next_state.cmd = state.cmd;
          endcase
        end
      end
      swdp_pkg::ST_ADDR: begin
        if (pop) begin
          next_state.bsel = ~state.bsel;
          if (!state.bsel) begin
            next_state.addr[15:8] = fifo_data;
          end else begin
            next_state.addr[7:0] = fifo_data;
            // reads go straight to the access
            next_state.fsm = state.cmd[`SWDP_CMD_READ_BIT] ? swdp_pkg::ST_WAIT
                             : swdp_pkg::ST_WDATA;
          end
        end
      end
      swdp_pkg::ST_WDATA: begin
        if (pop) begin
          next_state.bsel = ~state.bsel;
          if (!state.bsel) begin
            next_state.wdata[15:8] = fifo_data;
          end else begin
            next_state.wdata[7:0] = fifo_data;
            next_state.fsm = swdp_pkg::ST_WAIT;
          end
        end
      end
      swdp_pkg::ST_WAIT: begin
        next_state.steal = state.steal + 8'd1;
        mapped = state.cmd[`SWDP_CMD_MAP_BIT];
        // use a free cycle or steal one
        if (i_free_cycle || state.steal == `SWDP_STEAL_CYC - 8'd1) begin
          stat[`SWDP_STAT_EN_BIT] = state.fw_en;
          stat[`SWDP_STAT_ACT_BIT] = state.active;
          if (state.addr[15:1] == `SWDP_STATUS_ADDR >> 1) begin
            regw = {8'h00, stat};
          end
          if (mapped && state.addr >= `SWDP_DBG_REG_LO && state.addr <= `SWDP_DBG_REG_HI) begin
            // firmware enable lives in the status byte
            if (!state.cmd[`SWDP_CMD_READ_BIT] && state.addr[15:1] == `SWDP_STATUS_ADDR >> 1
                && (state.addr[0] != state.cmd[`SWDP_CMD_WORD_BIT])) begin
              next_state.fw_en = state.wdata[`SWDP_STAT_EN_BIT];
            end
            if (state.cmd[`SWDP_CMD_READ_BIT]) begin
              next_state.tx_sh = lane(!state.cmd[`SWDP_CMD_WORD_BIT], state.addr[0], regw);
              next_state.tx_left = `SWDP_WORD_BITS;
              next_state.fsm = swdp_pkg::ST_SEND;
            end else begin
              next_state.fsm = swdp_pkg::ST_IDLE;
            end
          end else begin
            next_state.freeze = !i_free_cycle;
            next_state.mem_req = 1'b1;
            next_state.mem_we = !state.cmd[`SWDP_CMD_READ_BIT];
            next_state.mem_byte = !state.cmd[`SWDP_CMD_WORD_BIT];
            // debug space enabled for this access only
            next_state.mem_dbg = mapped;
            next_state.fsm = swdp_pkg::ST_MEM;
          end
        end
      end
      swdp_pkg::ST_MEM: begin
        if (i_mem_ack) begin
          next_state.mem_req = 1'b0;
          next_state.mem_dbg = 1'b0;
          next_state.freeze = 1'b0;
          if (state.cmd[`SWDP_CMD_READ_BIT]) begin
            next_state.tx_sh = lane(state.mem_byte, state.addr[0], i_mem_rdata);
            next_state.tx_left = `SWDP_WORD_BITS;
            next_state.fsm = swdp_pkg::ST_SEND;
          end else begin
            next_state.fsm = swdp_pkg::ST_IDLE;
          end
        end
      end
      swdp_pkg::ST_SEND: begin
        if (state.tx_left == 5'd0 && !state.tx_on) begin
          next_state.fsm = swdp_pkg::ST_IDLE;
        end
      end
      default: next_state.fsm = swdp_pkg::ST_IDLE;
    endcase

    // idle line drops any half-done command
    if (state.idle == `SWDP_TIMEOUT_CYC - 11'd1 && !fall) begin
      next_state.fsm = swdp_pkg::ST_IDLE;
      next_state.rx_n = 3'd0;
      next_state.tx_left = 5'd0;
      next_state.bsel = 1'b0;
    end
    next_state.hold = next_state.freeze | (next_state.deny != 4'd0);

    // ----------------------------------------
    // wire drive, registered from next count
    // ----------------------------------------
    // released unless inside a drive window
    next_state.wire_oe = 1'b0;
    next_state.wire_out = 1'b0;
    if (next_state.tx_on) begin
      if (!next_state.txbit) begin
        // zero: low then short high kick
        if (next_state.cnt < `SWDP_ZERO_LOW_CYC) begin
          next_state.wire_oe = 1'b1;
        end else if (next_state.cnt == `SWDP_ZERO_LOW_CYC) begin
          next_state.wire_oe = 1'b1;
          next_state.wire_out = 1'b1;
        end
      end else if (next_state.cnt == `SWDP_ONE_PULSE_CYC) begin
        next_state.wire_oe = 1'b1;
        next_state.wire_out = 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_wire_out = state.wire_out;
  assign o_wire_oe = state.wire_oe;
  assign o_mem_req = state.mem_req;
  assign o_mem_we = state.mem_we;
  assign o_mem_byte = state.mem_byte;
  assign o_mem_dbg_map = state.mem_dbg;
  assign o_mem_addr = state.addr;
  assign o_mem_wdata = state.wdata;
  assign o_cpu_freeze = state.hold;
  // active mode maps registers and rom
  assign o_background_debug_mode = state.active;
  assign o_debug_firmware_enable = state.fw_en;
  assign o_periph_suspend = state.active;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_low8;
    (o_wire_oe && !o_wire_out) [*8];
  endsequence
  sequence s_low5_kick;
    (o_wire_oe && !o_wire_out) [*5] ##1 (o_wire_oe && o_wire_out) ##1 !o_wire_oe;
  endsequence

  a_zero_shape: assert property (
    $rose(o_wire_oe && !o_wire_out) |-> s_low8 ##1 s_low5_kick)
    else $error("zero bit drive shape wrong");
  a_one_pulse: assert property (
    state.busy && state.tx_on && state.txbit && state.cnt == 5'd0
    |-> !o_wire_oe [*7] ##1 (o_wire_oe && o_wire_out) ##1 !o_wire_oe)
    else $error("one bit pulse not at cycle seven");
  a_sample_ten: assert property (
    state.busy && !state.tx_on && state.cnt == 5'd0 && !fall
    |-> !rx_samp [*8] ##1 !rx_samp [*2] ##1 rx_samp)
    else $error("receive sample not ten cycles in");
  a_wire_release: assert property (
    !state.tx_on || state.cnt > `SWDP_ZERO_LOW_CYC |-> !o_wire_oe)
    else $error("wire driven outside transmit");
  a_idle_timeout: assert property (
    state.idle == 11'd511 && !fall |=> state.fsm == swdp_pkg::ST_IDLE && state.rx_n == 3'd0)
    else $error("timeout did not clear command");
  a_steal_freeze: assert property (
    state.fsm == swdp_pkg::ST_WAIT && state.steal == 8'd127 && !i_free_cycle
    |=> o_cpu_freeze == o_mem_req && state.fsm != swdp_pkg::ST_WAIT)
    else $error("cycle steal did not freeze cpu");
  a_bg_entry: assert property (
    state.bg_req && i_insn_boundary && state.fw_en |=> o_background_debug_mode)
    else $error("background entry missed boundary");
  a_deny_entry: assert property (
    trig && !state.fw_en && !state.active |=> !o_background_debug_mode && o_cpu_freeze)
    else $error("entry without firmware enable");
  a_map_scope: assert property (
    o_mem_dbg_map |-> o_mem_req)
    else $error("debug map outside access");
  a_strap_active: assert property (
    $rose(state.strap_done) && $past(i_special_single_chip)
    |-> o_background_debug_mode && o_debug_firmware_enable)
    else $error("special mode not active at reset");
endmodule

/* File: bench/swdp_host.sv */
// host side model of the single debug wire
`timescale 1ns/1ps
module swdp_host (
  input wire logic i_mclk,
  input wire logic i_wire,
  output logic o_pull_low
);
  initial o_pull_low = 1'b0;
  // falling edge per bit, msb first
  task automatic send_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      @(posedge i_mclk) o_pull_low <= 1'b1;
      repeat (v[i] ? 4 : 16) @(posedge i_mclk);
      o_pull_low <= 1'b0;
      repeat (v[i] ? 17 : 5) @(posedge i_mclk);
    end
  endtask
  // short low, release, sample ten cycles in
  // low outlasts the target's edge pickup, so a zero shows no high gap
  task automatic recv_word(output logic [15:0] v);
    for (int i = 15; i >= 0; i--) begin
      @(posedge i_mclk) o_pull_low <= 1'b1;
      repeat (5) @(posedge i_mclk);
      o_pull_low <= 1'b0;
      repeat (5) @(posedge i_mclk);
      #1 v[i] = i_wire;
      repeat (12) @(posedge i_mclk);
    end
  endtask
endmodule

/* File: bench/swdp_port_tb.sv */
// self-checking bench of the single-wire debug port
`timescale 1ns/1ps
module swdp_port_tb;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_free_cycle = 1'b0;
  logic i_mem_ack = 1'b0;
  logic [15:0] i_mem_rdata = 16'h0000;
  logic i_insn_boundary = 1'b0;
  logic i_tag_hit = 1'b0;
  logic i_enter_debug_instruction_insn = 1'b0;
  logic i_fw_go = 1'b0;
  logic i_special_single_chip = 1'b0;
  logic o_wire_out, o_wire_oe, o_mem_req, o_mem_we, o_mem_byte, o_mem_dbg_map;
  logic o_cpu_freeze, o_background_debug_mode, o_debug_firmware_enable, o_periph_suspend;
  logic [15:0] o_mem_addr;
  logic [15:0] o_mem_wdata;
  logic host_low;
  logic host_tx = 1'b0;
  logic free_en = 1'b1;
  logic bnd_en = 1'b1;
  logic [15:0] rd_word = 16'h0000;
  logic [15:0] acc_addr, acc_wdata;
  logic acc_we, acc_byte, acc_dbg, acc_frz;
  logic [7:0] hw_codes [8] = '{8'hC0, 8'hC4, 8'hC8, 8'hCC, 8'hE0, 8'hE4, 8'hE8, 8'hEC};
  int n_acc = 0;
  int n_frz = 0;
  int wt = 0;
  int n_errors = 0;
  int num_checks = 0;
  // pull-up wins only when nobody drives
  wire wire_lvl = host_low ? 1'b0 : (o_wire_oe ? o_wire_out : 1'b1);

  always #4 i_mclk = ~i_mclk;

  swdp_port DUT (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_wire_in(wire_lvl), .o_wire_out(o_wire_out),
    .o_wire_oe(o_wire_oe), .i_free_cycle(i_free_cycle), .i_mem_ack(i_mem_ack),
    .i_mem_rdata(i_mem_rdata), .o_mem_req(o_mem_req), .o_mem_we(o_mem_we),
    .o_mem_byte(o_mem_byte), .o_mem_dbg_map(o_mem_dbg_map), .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata), .o_cpu_freeze(o_cpu_freeze),
    .i_insn_boundary(i_insn_boundary), .i_tag_hit(i_tag_hit), .i_enter_debug_instruction_insn(i_enter_debug_instruction_insn),
    .i_fw_go(i_fw_go), .i_special_single_chip(i_special_single_chip),
    .o_background_debug_mode(o_background_debug_mode),
    .o_debug_firmware_enable(o_debug_firmware_enable), .o_periph_suspend(o_periph_suspend)
  );
  swdp_host host (.i_mclk(i_mclk), .i_wire(wire_lvl), .o_pull_low(host_low));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ----
  // memory side and cpu activity
  // ----
  always @(posedge i_mclk) begin
    i_free_cycle <= free_en & 1'($urandom % 2);
    i_insn_boundary <= bnd_en & 1'($urandom % 2);
    i_mem_ack <= (o_mem_req === 1'b1) && !i_mem_ack && wt == 0;
    if (o_cpu_freeze === 1'b1) n_frz <= n_frz + 1;
    if (o_mem_req === 1'b1 && !i_mem_ack) begin
      if (wt == 0) begin
        i_mem_rdata <= rd_word;
        {acc_we, acc_byte, acc_dbg, acc_frz} <= {o_mem_we, o_mem_byte, o_mem_dbg_map, o_cpu_freeze};
        acc_addr <= o_mem_addr;
        acc_wdata <= o_mem_wdata;
        n_acc <= n_acc + 1;
        wt <= $urandom % 4;
      end else begin
        wt <= wt - 1;
      end
    end
    if (host_tx && o_wire_oe !== 1'b0) chk("wire_oe", 16'h0000, 16'(o_wire_oe));
  end

  task automatic send_cmd(input logic [7:0] c);
    host_tx = 1'b1;
    host.send_byte(c);
    host_tx = 1'b0;
  endtask

  task automatic run_cmd(input logic [7:0] c, input logic [15:0] a, input logic [15:0] d,
                         input int nexp, output logic [15:0] r);
    int n0;
    n0 = n_acc;
    r = 16'h0000;
    host_tx = 1'b1;
    host.send_byte(c);
    host.send_byte(a[15:8]);
    host.send_byte(a[7:0]);
    if (!c[5]) begin
      host.send_byte(d[15:8]);
      host.send_byte(d[7:0]);
    end
    host_tx = 1'b0;
    repeat (150) @(posedge i_mclk);
    if (c[5]) host.recv_word(r);
    #1;
    chk("access_count", 16'(n0 + nexp), 16'(n_acc));
  endtask

  task automatic enter_exit(input int src);
    logic [15:0] r;
    if (src == 2) begin
      bnd_en <= 1'b0;
      send_cmd(8'h90);
      repeat (30) @(posedge i_mclk);
      #1;
      chk("mode_early", 16'h0000, 16'(o_background_debug_mode));
      bnd_en <= 1'b1;
      repeat (20) @(posedge i_mclk);
    end else begin
      @(posedge i_mclk);
      if (src == 0) i_enter_debug_instruction_insn <= 1'b1;
      else i_tag_hit <= 1'b1;
      @(posedge i_mclk);
      i_enter_debug_instruction_insn <= 1'b0;
      i_tag_hit <= 1'b0;
      repeat (2) @(posedge i_mclk);
    end
    #1;
    chk("mode", 16'h0001, 16'(o_background_debug_mode));
    chk("suspend", 16'h0001, 16'(o_periph_suspend));
    if (src == 2) begin
      run_cmd(8'hE4, 16'hFF01, 16'h0000, 0, r);
      chk("status", 16'h00C0, r);
    end
    @(posedge i_mclk) i_fw_go <= 1'b1;
    @(posedge i_mclk) i_fw_go <= 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
    chk("mode_off", 16'h0000, 16'(o_background_debug_mode));
    chk("suspend_off", 16'h0000, 16'(o_periph_suspend));
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    logic [15:0] a, d, r, e;
    logic [7:0] c;
    int nf;
    void'($urandom(76819));
    repeat (6) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
    chk("mode_reset", 16'h0000, 16'(o_background_debug_mode));
    for (int k = 0; k < 16; k++) begin
      c = hw_codes[k % 8];
      a = {1'b0, 15'($urandom)};
      // words aligned, bytes on both lanes
      a[0] = c[3] ? 1'b0 : 1'(k / 8);
      d = 16'($urandom);
      rd_word = 16'($urandom);
      run_cmd(c, a, d, 1, r);
      chk("mem_we", 16'(!c[5]), 16'(acc_we));
      chk("mem_byte", 16'(!c[3]), 16'(acc_byte));
      chk("dbg_map", 16'(c[2]), 16'(acc_dbg));
      chk("mem_addr", a, acc_addr);
      chk("free_freeze", 16'h0000, 16'(acc_frz));
      if (!c[5]) chk("mem_wdata", d, acc_wdata);
      e = c[3] ? rd_word : (a[0] ? {8'h00, rd_word[7:0]} : {rd_word[15:8], 8'h00});
      if (c[5]) chk("read_data", e, r);
    end
    $display("test commands done");
    free_en <= 1'b0;
    run_cmd(8'hC8, 16'h0100, 16'h4321, 1, r);
    chk("steal_freeze", 16'h0001, 16'(acc_frz));
    free_en <= 1'b1;
    send_cmd(8'hC0);
    repeat (600) @(posedge i_mclk);
    run_cmd(8'hC8, 16'h0246, 16'h1357, 1, r);
    chk("timeout_addr", 16'h0246, acc_addr);
    chk("timeout_data", 16'h1357, acc_wdata);
    $display("test steal and timeout done");
    nf = n_frz;
    send_cmd(8'h90);
    repeat (40) @(posedge i_mclk);
    #1;
    chk("refused_freeze", 16'h0008, 16'(n_frz - nf));
    chk("refused_mode", 16'h0000, 16'(o_background_debug_mode));
    run_cmd(8'hC4, 16'hFF01, 16'h0080, 0, r);
    chk("fw_enable", 16'h0001, 16'(o_debug_firmware_enable));
    run_cmd(8'hC4, 16'hFF00, 16'h0000, 0, r);
    chk("fw_keep", 16'h0001, 16'(o_debug_firmware_enable));
    for (int s = 0; s < 3; s++) enter_exit(s);
    $display("test mode done");
    @(posedge i_mclk);
    i_special_single_chip <= 1'b1;
    i_rst <= 1'b1;
    repeat (6) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_mclk);
    #1;
    chk("strap_mode", 16'h0001, 16'(o_background_debug_mode));
    chk("strap_enable", 16'h0001, 16'(o_debug_firmware_enable));
    $display("test strap done");
    test_done();
  end

  // about three and a half times the expected run length
  initial begin
    repeat (80000) @(posedge i_mclk);
    n_errors++;
    $display("watchdog expired");
    test_done();
  end
endmodule
